// *** hdl/conv_ctrl.sv ***
// Pin-mode capture, host data bus and conversion control
`timescale 1ns/1ps
`include "conv_ctrl_defines.svh"
module conv_ctrl import conv_ctrl_pkg::*; #(
    parameter int unsigned WR_WAKE_CYC   = `WR_WAKE_CYC,
    parameter int unsigned CONV_WAKE_CYC = `CONV_WAKE_CYC,
    parameter int unsigned CONV_CYC      = 100
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Device reset pin, active low
    input  wire logic        reset_pin_n,
    // Mode strap pins
    input  wire logic [1:0]  range_and_ctrl_mode_pins,
    input  wire logic        interface_select_pin,
    input  wire logic        sequencer_enable_pin,
    // Conversion control pins
    input  wire logic [2:0]  channel_pair_select,
    input  wire logic        conversion_start,
    output logic             busy,
    // Bus strobes
    input  wire logic        cs_n,
    input  wire logic        rd_sclk_n,
    input  wire logic        wr_burst_n,
    // Data bus pins
    input  wire logic [15:0] data_bus_lines_in,
    output logic      [15:0] data_bus_lines_out,
    output logic      [15:0] data_bus_lines_oe,
    // Results from the converter core
    input  wire logic [15:0] result_a,
    input  wire logic [15:0] result_b,
    // Control towards the converter core
    output logic             convert_go,
    output logic      [2:0]  convert_pair,
    output logic      [2:0]  oversample_ratio,
    output logic             shutdown,
    // Captured configuration and programming words
    output logic             sw_mode,
    output iface_e           iface_mode,
    output logic             burst_en,
    output logic             seq_en,
    output logic             write_ready,
    output logic             conv_ready,
    output logic      [15:0] prog_word,
    output logic             prog_valid
);
    localparam int W_SYNC = 28;

    logic [W_SYNC-1:0] sync_q;
    logic        rpin;
    logic [1:0]  mode_q;
    logic        ifsel_q;
    logic        seq_q;
    logic [2:0]  chsel_q;
    logic        cvst_q;
    logic        cs_q;
    logic        rd_q;
    logic        wr_q;
    logic [15:0] db_q;
    logic        cs_prev;
    logic        rd_prev;
    logic        cvst_prev;
    logic        wr_act_prev;
    logic [7:0]  low_cnt;
    logic        cfg_pending;
    logic [20:0] wake_cnt;
    logic [15:0] res_a;
    logic [15:0] res_b;
    logic        rd_word;
    logic        rd_byte;
    logic        wr_byte;
    logic [7:0]  wr_high;
    logic [15:0] conv_cnt;
    logic [2:0]  seq_pos;
    logic [2:0]  last_pair;
    conv_state_e cstate;
    logic        cs_fall;
    logic        cs_rise;
    logic        rd_act;
    logic        wr_act;
    logic        start_edge;
    logic        conv_end;
    logic [15:0] rd_sel;
    logic [15:0] conv_len;

    serial_link_if lnk ();

    pin_sync #(.W(W_SYNC)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  ({reset_pin_n, range_and_ctrl_mode_pins,
                   interface_select_pin, sequencer_enable_pin,
                   channel_pair_select, conversion_start, cs_n,
                   rd_sclk_n, wr_burst_n, data_bus_lines_in}),
        .pin_out (sync_q)
    );

    serial_shifter u_shift (
        .sys_clk (sys_clk),
        .rst     (rst),
        .lnk     (lnk)
    );

    assign {rpin, mode_q, ifsel_q, seq_q, chsel_q, cvst_q, cs_q, rd_q, wr_q,
            db_q} = sync_q;

    assign cs_fall    = cs_prev & ~cs_q;
    assign cs_rise    = ~cs_prev & cs_q;
    assign rd_act     = ~cs_q & ~rd_q;
    assign wr_act     = ~cs_q & ~wr_q;
    assign start_edge = cvst_q & ~cvst_prev;
    assign conv_len   = 16'(CONV_CYC) << oversample_ratio;
    assign conv_end   = (cstate == CV_RUN) && (conv_cnt == conv_len);
    assign rd_sel     = rd_word ? res_b : res_a;

    // Serial link hookup
    assign lnk.frame_start = cs_fall;
    assign lnk.sclk_rise   = ~cs_q & rd_q & ~rd_prev;
    assign lnk.sclk_fall   = ~cs_q & ~rd_q & rd_prev;
    assign lnk.sdi         = db_q[`SDI_POS];
    assign lnk.load_a      = res_a;
    assign lnk.load_b      = res_b;

    // Edge history
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cs_prev     <= 1'b0;
            rd_prev     <= 1'b0;
            cvst_prev   <= 1'b0;
            wr_act_prev <= 1'b0;
        end else begin
            cs_prev     <= cs_q;
            rd_prev     <= rd_q;
            cvst_prev   <= cvst_q;
            wr_act_prev <= wr_act;
        end
    end

    // Shutdown detect on long reset-pin low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_cnt  <= 8'h00;
            shutdown <= 1'b0;
        end else if (rpin) begin
            low_cnt  <= 8'h00;
            shutdown <= 1'b0;
        end else if (low_cnt < 8'(`SHUTDOWN_CYC)) begin
            low_cnt <= low_cnt + 8'h01;
        end else begin
            shutdown <= 1'b1;
        end
    end

    // Strap capture at release of full reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_pending      <= 1'b1;
            sw_mode          <= 1'b1;
            iface_mode       <= IF_PARALLEL;
            burst_en         <= 1'b0;
            seq_en           <= 1'b0;
            oversample_ratio <= 3'h0;
        end else if (shutdown) begin
            cfg_pending      <= 1'b1;
            sw_mode          <= 1'b1;
            iface_mode       <= IF_PARALLEL;
            burst_en         <= 1'b0;
            seq_en           <= 1'b0;
            oversample_ratio <= 3'h0;
        end else if (cfg_pending && rpin) begin
            cfg_pending <= 1'b0;
            sw_mode     <= (mode_q == `SW_MODE_CODE);
            if (!ifsel_q) begin
                iface_mode <= IF_PARALLEL;
            end else if (db_q[`BYTESEL_POS]) begin
                iface_mode <= IF_BYTE;
            end else begin
                iface_mode <= IF_SERIAL;
            end
            burst_en <= (mode_q != `SW_MODE_CODE) & wr_q;
            seq_en   <= (mode_q != `SW_MODE_CODE) & seq_q;
            if (mode_q != `SW_MODE_CODE && ifsel_q && !db_q[`BYTESEL_POS])
            begin
                oversample_ratio <= {db_q[`OS_B2_POS], db_q[`OS_B1_POS],
                                     db_q[`OS_B0_POS]};
            end else begin
                oversample_ratio <= 3'h0;
            end
        end
    end

    // Wake-up timers after leaving reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_cnt    <= 21'h000000;
            write_ready <= 1'b0;
            conv_ready  <= 1'b0;
        end else if (cfg_pending || !rpin) begin
            wake_cnt    <= 21'h000000;
            write_ready <= 1'b0;
            conv_ready  <= 1'b0;
        end else begin
            if (!conv_ready) begin
                wake_cnt <= wake_cnt + 21'h000001;
            end
            if (wake_cnt == 21'(WR_WAKE_CYC)) begin
                write_ready <= 1'b1;
            end
            if (wake_cnt == 21'(CONV_WAKE_CYC)) begin
                conv_ready <= 1'b1;
            end
        end
    end

    // Programming writes, software mode only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prog_word  <= 16'h0000;
            prog_valid <= 1'b0;
            wr_byte    <= 1'b0;
            wr_high    <= 8'h00;
        end else begin
            prog_valid <= 1'b0;
            if (cs_fall) begin
                wr_byte <= 1'b0;
            end
            if (!sw_mode || !write_ready) begin
                wr_byte <= 1'b0;
            end else if (iface_mode == IF_SERIAL) begin
                if (lnk.rx_valid) begin
                    prog_word  <= lnk.rx_word;
                    prog_valid <= 1'b1;
                end
            end else if (wr_act && !wr_act_prev) begin
                if (iface_mode == IF_PARALLEL) begin
                    prog_word  <= db_q;
                    prog_valid <= 1'b1;
                end else if (!wr_byte) begin
                    wr_high <= db_q[7:0];
                    wr_byte <= 1'b1;
                end else begin
                    prog_word  <= {wr_high, db_q[7:0]};
                    prog_valid <= 1'b1;
                    wr_byte    <= 1'b0;
                end
            end
        end
    end

    // Read pointer: word A then B, high byte first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_word <= 1'b0;
            rd_byte <= 1'b0;
        end else if (cs_fall) begin
            rd_word <= 1'b0;
            rd_byte <= 1'b0;
        end else if (iface_mode != IF_SERIAL && !cs_q && rd_q && !rd_prev)
        begin
            if (iface_mode == IF_PARALLEL || rd_byte) begin
                rd_word <= ~rd_word;
                rd_byte <= 1'b0;
            end else begin
                rd_byte <= 1'b1;
            end
        end
    end

    // Data bus drive
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_bus_lines_out <= 16'h0000;
            data_bus_lines_oe  <= 16'h0000;
        end else if (cs_q || cs_rise) begin
            data_bus_lines_out <= 16'h0000;
            data_bus_lines_oe  <= 16'h0000;
        end else if (iface_mode == IF_SERIAL) begin
            data_bus_lines_out <= 16'h0000;
            data_bus_lines_out[`SDOA_POS] <= lnk.sdo_a;
            data_bus_lines_out[`SDOB_POS] <= lnk.sdo_b;
            data_bus_lines_oe  <= 16'h0000;
            data_bus_lines_oe[`SDOA_POS]  <= 1'b1;
            data_bus_lines_oe[`SDOB_POS]  <= 1'b1;
        end else if (rd_act && !wr_act) begin
            if (iface_mode == IF_PARALLEL) begin
                data_bus_lines_out <= rd_sel;
                data_bus_lines_oe  <= 16'hffff;
            end else begin
                data_bus_lines_out <= {8'h00,
                                       rd_byte ? rd_sel[7:0] : rd_sel[15:8]};
                data_bus_lines_oe  <= 16'h00ff;
            end
        end else begin
            data_bus_lines_out <= 16'h0000;
            data_bus_lines_oe  <= 16'h0000;
        end
    end

    // Conversion sequencing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cstate       <= CV_IDLE;
            busy         <= 1'b0;
            conv_cnt     <= 16'h0000;
            convert_go   <= 1'b0;
            convert_pair <= 3'h0;
            seq_pos      <= 3'h0;
            last_pair    <= 3'h0;
            res_a        <= 16'h0000;
            res_b        <= 16'h0000;
        end else if (shutdown || cfg_pending) begin
            cstate     <= CV_IDLE;
            busy       <= 1'b0;
            convert_go <= 1'b0;
            seq_pos    <= 3'h0;
        end else begin
            convert_go <= 1'b0;
            case (cstate)
                CV_IDLE: begin
                    if (start_edge && conv_ready) begin
                        busy       <= 1'b1;
                        convert_go <= 1'b1;
                        conv_cnt   <= 16'h0001;
                        last_pair  <= chsel_q;
                        cstate     <= CV_RUN;
                        if (sw_mode) begin
                            convert_pair <= 3'h0;
                        end else if (burst_en) begin
                            convert_pair <= 3'h0;
                        end else if (seq_en) begin
                            convert_pair <= seq_pos;
                        end else begin
                            convert_pair <= chsel_q;
                        end
                    end
                end
                CV_RUN: begin
                    conv_cnt <= conv_cnt + 16'h0001;
                    if (conv_end) begin
                        res_a  <= result_a;
                        res_b  <= result_b;
                        cstate <= CV_DONE;
                    end
                end
                CV_DONE: begin
                    if (!sw_mode && burst_en && convert_pair != last_pair)
                    begin
                        convert_pair <= convert_pair + 3'h1;
                        convert_go   <= 1'b1;
                        conv_cnt     <= 16'h0001;
                        cstate       <= CV_RUN;
                    end else begin
                        busy   <= 1'b0;
                        cstate <= CV_IDLE;
                        if (!sw_mode && seq_en && !burst_en) begin
                            seq_pos <= (seq_pos == last_pair) ? 3'h0 :
                                       seq_pos + 3'h1;
                        end
                    end
                end
                default: begin
                    cstate <= CV_IDLE;
                    busy   <= 1'b0;
                end
            endcase
        end
    end
endmodule

// *** hdl/conv_ctrl_defines.svh ***
// Constants for the converter pin-mode and conversion control block
// Function
// - HW serial: data pins 13,14,15 give oversample bits
// - SW parallel pins take writes; HW read-only
// - SW parallel: select plus write takes 16 lines
// - SW byte: select plus write takes 8 lines
// - HW mode latches burst enable at reset release
// - Serial accesses timed on serial clock rise
// - Select plus read drives 16 or 8 lines; none while write strobe is also low
// - Select rising edge floats all data lines
// - Select falling edge starts new output frame
// - Serial framing is SPI mode 00
// - HW, sequencer off: channel pins pick pair; with burst on they give last pair
// - HW, sequencer on: channel pins give last pair
// - Busy rises after start, falls when latched
// - Start edges ignored while busy
// - Burst: one start runs whole sequence
// - Normal/sequencer: one start converts one pair
// - Mode pins at reset pick software or hardware
// - Reset low over 1.2 us means shutdown
// - Wake-up: 240 us to write, 15 ms to convert
// - Byte-select level at reset picks byte or serial
`ifndef CONV_CTRL_DEFINES_SVH
`define CONV_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS   10
`define SHUTDOWN_NS     1200
`define SHUTDOWN_CYC    ((`SHUTDOWN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_WAKE_US      240
`define WR_WAKE_CYC     (`WR_WAKE_US * 1000 / `CLK_PERIOD_NS)
`define CONV_WAKE_MS    15
`define CONV_WAKE_CYC   (`CONV_WAKE_MS * 1000000 / `CLK_PERIOD_NS)
`define SW_MODE_CODE    2'h0
`define OS_B0_POS       13
`define OS_B1_POS       14
`define OS_B2_POS       15
`define BYTESEL_POS     9
`define SDI_POS         10
`define SDOB_POS        11
`define SDOA_POS        12
`define WORD_BITS       16
`endif

// *** hdl/conv_ctrl_pkg.sv ***
// Types for the converter pin-mode and conversion control block
package conv_ctrl_pkg;
    typedef enum logic [1:0] {IF_PARALLEL, IF_BYTE, IF_SERIAL} iface_e;
    typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_DONE} conv_state_e;
endpackage

// *** hdl/serial_link_if.sv ***
// Signals between the control core and the serial shifter
`timescale 1ns/1ps
interface serial_link_if;
    logic        frame_start;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sdi;
    logic [15:0] load_a;
    logic [15:0] load_b;
    logic        sdo_a;
    logic        sdo_b;
    logic [15:0] rx_word;
    logic        rx_valid;
    modport core (output frame_start, sclk_rise, sclk_fall, sdi, load_a,
                  load_b, input sdo_a, sdo_b, rx_word, rx_valid);
    modport shifter (input frame_start, sclk_rise, sclk_fall, sdi, load_a,
                     load_b, output sdo_a, sdo_b, rx_word, rx_valid);
endinterface

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Pins in, synchronised out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1  <= '0;
            pin_out <= '0;
        end else begin
            stage1  <= pin_in;
            pin_out <= stage1;
        end
    end
endmodule

// *** hdl/serial_shifter.sv ***
// SPI mode 00 shifter for the serial interface
`timescale 1ns/1ps
module serial_shifter (
    // Clock and reset
    input  wire logic    sys_clk,
    input  wire logic    rst,
    // Link to core
    serial_link_if.shifter lnk
);
    logic [15:0] sh_a;
    logic [15:0] sh_b;
    logic [15:0] rx;
    logic [3:0]  bit_cnt;

    assign lnk.sdo_a   = sh_a[15];
    assign lnk.sdo_b   = sh_b[15];
    assign lnk.rx_word = rx;

    // Output words: load at frame start, shift on falling edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh_a <= 16'h0000;
            sh_b <= 16'h0000;
        end else if (lnk.frame_start) begin
            sh_a <= lnk.load_a;
            sh_b <= lnk.load_b;
        end else if (lnk.sclk_fall) begin
            sh_a <= {sh_a[14:0], 1'b0};
            sh_b <= {sh_b[14:0], 1'b0};
        end
    end

    // Input word: sample on rising edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx           <= 16'h0000;
            bit_cnt      <= 4'h0;
            lnk.rx_valid <= 1'b0;
        end else begin
            lnk.rx_valid <= 1'b0;
            if (lnk.frame_start) begin
                bit_cnt <= 4'h0;
            end else if (lnk.sclk_rise) begin
                rx           <= {rx[14:0], lnk.sdi};
                bit_cnt      <= bit_cnt + 4'h1;
                lnk.rx_valid <= (bit_cnt == 4'hf);
            end
        end
    end
endmodule

// *** bench/conv_ctrl_monitor.sv ***
// Checker for the converter pin-mode and conversion control block
`timescale 1ns/1ps
module conv_ctrl_monitor import conv_ctrl_pkg::*; (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Host strobes
    input wire logic        cs_n,
    input wire logic        wr_burst_n,
    // Watched outputs
    input wire logic        busy,
    input wire logic [15:0] data_bus_lines_oe,
    input wire logic        convert_go,
    input wire logic [2:0]  oversample_ratio,
    input wire logic        shutdown,
    input wire logic        sw_mode,
    input wire iface_e      iface_mode,
    input wire logic        burst_en,
    input wire logic        write_ready,
    input wire logic        conv_ready,
    input wire logic        prog_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    go_on_busy_a: assert property ($rose(busy) |-> convert_go)
        else $error("busy rose without a start pulse");
    start_ignored_a: assert property (
        convert_go && !burst_en |-> $rose(busy))
        else $error("start taken while busy");
    busy_hold_a: assert property ($rose(busy) |-> busy [*8])
        else $error("busy fell before conversion end");
    cs_float_a: assert property (
        cs_n [*4] |-> data_bus_lines_oe == 16'h0)
        else $error("data lines driven with select high");
    byte_lines_a: assert property (
        iface_mode == IF_BYTE |-> data_bus_lines_oe[15:8] == 8'h0)
        else $error("upper lines driven in byte mode");
    prog_sw_a: assert property (prog_valid |-> sw_mode)
        else $error("programming word in hardware mode");
    prog_strobe_a: assert property (
        prog_valid && iface_mode != IF_SERIAL
        |-> !$past(cs_n, 3) && !$past(wr_burst_n, 3))
        else $error("programming word without strobes");
    os_mode_a: assert property (oversample_ratio != 3'h0
        |-> !sw_mode && iface_mode == IF_SERIAL)
        else $error("oversampling outside hardware serial");
    cfg_hold_a: assert property (write_ready
        |=> $stable(iface_mode) && $stable(sw_mode)
        && $stable(burst_en) && $stable(oversample_ratio))
        else $error("configuration changed after capture");
    burst_hw_a: assert property (burst_en |-> !sw_mode)
        else $error("burst enabled in software mode");
    shut_ready_a: assert property (
        shutdown |-> !write_ready && !conv_ready)
        else $error("ready while shut down");
endmodule

bind conv_ctrl conv_ctrl_monitor u_mon (
    .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .wr_burst_n(wr_burst_n),
    .busy(busy), .data_bus_lines_oe(data_bus_lines_oe),
    .convert_go(convert_go), .oversample_ratio(oversample_ratio),
    .shutdown(shutdown), .sw_mode(sw_mode), .iface_mode(iface_mode),
    .burst_en(burst_en), .write_ready(write_ready),
    .conv_ready(conv_ready), .prog_valid(prog_valid)
);

// *** bench/host_model.sv ***
// Host controller model for the converter data bus
`timescale 1ns/1ps
`include "conv_ctrl_defines.svh"
module host_model (
    // Clock
    input  wire logic        sys_clk,
    // Resolved data bus
    input  wire logic [15:0] bus,
    // Strobes and data drive
    output logic             cs_n,
    output logic             rd_sclk_n,
    output logic             wr_burst_n,
    output logic      [15:0] drv
);
    initial begin
        cs_n = 1'b1;
        rd_sclk_n = 1'b1;
        wr_burst_n = 1'b1;
        drv = 16'h0;
    end

    // Select and write strobe low together
    task automatic pwrite(input logic [15:0] w);
        @(negedge sys_clk);
        cs_n = 1'b0;
        wr_burst_n = 1'b0;
        drv = w;
        repeat (5) @(negedge sys_clk);
        cs_n = 1'b1;
        wr_burst_n = 1'b1;
        drv = 16'h0;
        repeat (5) @(negedge sys_clk);
    endtask

    // Two reads in one frame, word A then B, or A high then low byte in byte mode
    task automatic pread(output logic [15:0] a, output logic [15:0] b);
        @(negedge sys_clk);
        cs_n = 1'b0;
        rd_sclk_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        a = bus;
        rd_sclk_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd_sclk_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        b = bus;
        rd_sclk_n = 1'b1;
        cs_n = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask

    // Serial frame, clock idle low, sampled on rising edge
    task automatic sread(output logic [15:0] a, output logic [15:0] b);
        drv = 16'h0;
        rd_sclk_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (8) @(negedge sys_clk);
            rd_sclk_n = 1'b1;
            a[i] = bus[`SDOA_POS];
            b[i] = bus[`SDOB_POS];
            repeat (8) @(negedge sys_clk);
            rd_sclk_n = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        cs_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

// *** bench/conv_ctrl_tb.sv ***
// Self-checking bench for the converter pin-mode and conversion control
`timescale 1ns/1ps
module conv_ctrl_tb import conv_ctrl_pkg::*; ();
    localparam logic [15:0] RES_A = 16'h1234;
    localparam logic [15:0] RES_B = 16'hbeef;
    logic        sys_clk, rst, reset_pin_n, busy, convert_go, shutdown;
    logic        interface_select_pin, sequencer_enable_pin;
    logic        conversion_start, cs_n, rd_sclk_n, wr_burst_n;
    logic        sw_mode, burst_en, write_ready, conv_ready;
    logic        seq_en, prog_valid;
    logic [1:0]  range_pins;
    logic [2:0]  chan_sel, convert_pair, oversample_ratio;
    logic [15:0] bus, db_out, db_oe, drv, prog_word, a, b;
    iface_e      iface_mode;
    int          failures, n_checks, n_go, n_pv, g0;

    assign bus = (db_out & db_oe) | (drv & ~db_oe);

    conv_ctrl #(.WR_WAKE_CYC(50), .CONV_WAKE_CYC(100), .CONV_CYC(8)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
        .range_and_ctrl_mode_pins(range_pins),
        .interface_select_pin(interface_select_pin),
        .sequencer_enable_pin(sequencer_enable_pin),
        .channel_pair_select(chan_sel), .conversion_start(conversion_start),
        .busy(busy), .cs_n(cs_n), .rd_sclk_n(rd_sclk_n),
        .wr_burst_n(wr_burst_n), .data_bus_lines_in(bus),
        .data_bus_lines_out(db_out), .data_bus_lines_oe(db_oe),
        .result_a(RES_A), .result_b(RES_B), .convert_go(convert_go),
        .convert_pair(convert_pair), .oversample_ratio(oversample_ratio),
        .shutdown(shutdown), .sw_mode(sw_mode), .iface_mode(iface_mode),
        .burst_en(burst_en), .seq_en(seq_en), .write_ready(write_ready),
        .conv_ready(conv_ready), .prog_word(prog_word), .prog_valid(prog_valid)
    );

    host_model u_host (
        .sys_clk(sys_clk), .bus(bus), .cs_n(cs_n), .rd_sclk_n(rd_sclk_n),
        .wr_burst_n(wr_burst_n), .drv(drv)
    );

    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (convert_go === 1'b1) n_go++;
        if (prog_valid === 1'b1) n_pv++;
    end

    task automatic chkw(input logic [15:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic waitv(ref logic s, input logic v, input int n);
        for (int k = 0; k < n && s !== v; k++) @(negedge sys_clk);
        chkw(16'(s), 16'(v), "wait");
    endtask

    task automatic start();
        @(negedge sys_clk);
        conversion_start = 1'b1;
        repeat (3) @(negedge sys_clk);
        conversion_start = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        results();
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        reset_pin_n = 1'b1;
        range_pins = 2'h0;
        interface_select_pin = 1'b0;
        sequencer_enable_pin = 1'b0;
        chan_sel = 3'h0;
        conversion_start = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        // Software parallel: write, convert, read
        waitv(write_ready, 1'b1, 200);
        chkw(16'(sw_mode), 16'h1, "ctrl mode");
        chkw(16'(iface_mode), 16'(IF_PARALLEL), "iface");
        u_host.pwrite(16'ha5c3);
        chkw(prog_word, 16'ha5c3, "prog word");
        waitv(conv_ready, 1'b1, 200);
        g0 = n_go;
        start();
        start();
        waitv(busy, 1'b0, 100);
        chkw(16'(n_go - g0), 16'h1, "go count");
        u_host.pread(a, b);
        chkw(a, RES_A, "read a");
        chkw(b, RES_B, "read b");
        $display("test software parallel done");
        // Full reset into software byte
        u_host.drv = 16'h0200;
        interface_select_pin = 1'b1;
        reset_pin_n = 1'b0;
        repeat (130) @(negedge sys_clk);
        reset_pin_n = 1'b1;
        waitv(write_ready, 1'b1, 300);
        chkw(16'(iface_mode), 16'(IF_BYTE), "iface");
        u_host.pwrite(16'h00ab);
        u_host.pwrite(16'h00cd);
        chkw(prog_word, 16'habcd, "byte word");
        chkw(16'(n_pv), 16'h2, "prog pulses");
        u_host.pread(a, b);
        chkw(a, 16'h0012, "byte hi");
        chkw(b, 16'h0034, "byte lo");
        $display("test software byte done");
        // Full reset into hardware serial with burst
        u_host.drv = 16'hc000;
        range_pins = 2'h1;
        interface_select_pin = 1'b1;
        sequencer_enable_pin = 1'b1;
        chan_sel = 3'h2;
        reset_pin_n = 1'b0;
        repeat (130) @(negedge sys_clk);
        chkw(16'(shutdown), 16'h1, "shutdown");
        reset_pin_n = 1'b1;
        waitv(conv_ready, 1'b1, 300);
        chkw(16'(sw_mode), 16'h0, "ctrl mode");
        chkw(16'(iface_mode), 16'(IF_SERIAL), "iface");
        chkw(16'(oversample_ratio), 16'h6, "oversample");
        chkw(16'(burst_en), 16'h1, "burst");
        chkw(16'(seq_en), 16'h1, "sequencer");
        u_host.drv = 16'h0;
        range_pins = 2'h0;
        interface_select_pin = 1'b0;
        sequencer_enable_pin = 1'b0;
        repeat (10) @(negedge sys_clk);
        chkw(16'({sw_mode, seq_en, oversample_ratio}), 16'he, "held");
        $display("test hardware capture done");
        g0 = n_go;
        start();
        waitv(busy, 1'b0, 3000);
        chkw(16'(n_go - g0), 16'h3, "burst pairs");
        chkw(16'(convert_pair), 16'h2, "last pair");
        u_host.sread(a, b);
        chkw(a, RES_A, "serial a");
        chkw(b, RES_B, "serial b");
        $display("test hardware serial burst done");
        results();
    end
endmodule
